// ==== core/osc_tick.sv ====
// divides the reference clock down to the internal oscillator tick
`timescale 1ns/10ps
`default_nettype none
module osc_tick
    import wake_timer_pkg::*;
#(
    // reference cycles per oscillator tick; a bench may shorten it to keep runs short
    parameter int unsigned DIV = TICK_CYCLES
)
(
    input  wire logic   i_ref_clk,
    input  wire logic   i_rst,
    tick_if.source      tk
);
    logic [TICK_CNT_W-1:0] div_cnt;
    wire                   div_end = (div_cnt == TICK_CNT_W'(DIV - 1));

    // one-cycle tick every oscillator period
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_cnt <= '0;
            tk.tick <= 1'b0;
        end else begin
            div_cnt <= div_end ? '0 : div_cnt + 1'b1;
            tk.tick <= div_end;
        end
    end
endmodule : osc_tick
`default_nettype wire

// ==== core/tick_if.sv ====
// oscillator tick carried from the tick generator to the controller
`timescale 1ns/10ps
`default_nettype none
interface tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input tick);
endinterface : tick_if
`default_nettype wire

// ==== core/wake_timer_pkg.sv ====
// constants and types shared by the wake timer watchdog design
package wake_timer_pkg;

    // reference clock and internal oscillator tick
    localparam int unsigned REF_CLK_HZ         = 10_000_000;
    localparam int unsigned TICK_TIME_MS       = 10;
    localparam int unsigned TICK_CYCLES        = REF_CLK_HZ / 1000 * TICK_TIME_MS;
    localparam int unsigned TICK_CNT_W         = 17;

    // timing figures in milliseconds and their tick counts
    localparam int unsigned RESET_PULSE_TIME_MS       = 320;
    localparam int unsigned WAKE_PULSE_TIME_MS        = 20;
    localparam int unsigned ACK_GUARD_TIME_MS         = 20;
    localparam int unsigned DEBOUNCE_TIME_MS          = 20;
    localparam int unsigned RESISTOR_CONVERSION_MS    = 100;
    localparam int unsigned RESET_PULSE_TICKS  = RESET_PULSE_TIME_MS / TICK_TIME_MS;
    localparam int unsigned WAKE_PULSE_TICKS   = WAKE_PULSE_TIME_MS / TICK_TIME_MS;
    localparam int unsigned ACK_GUARD_TICKS    = ACK_GUARD_TIME_MS / TICK_TIME_MS;
    localparam int unsigned DEBOUNCE_TICKS     = DEBOUNCE_TIME_MS / TICK_TIME_MS;
    localparam int unsigned CONVERSION_TICKS   = RESISTOR_CONVERSION_MS / TICK_TIME_MS;

    // interval range 100 ms .. 7200 s counted in ticks
    localparam int unsigned INTERVAL_W         = 20;
    localparam int unsigned MIN_INTERVAL_MS    = 100;
    localparam int unsigned MAX_INTERVAL_S     = 7200;
    localparam logic [INTERVAL_W-1:0] MIN_INTERVAL_TICKS =
        INTERVAL_W'(MIN_INTERVAL_MS / TICK_TIME_MS);
    localparam logic [INTERVAL_W-1:0] MAX_INTERVAL_TICKS =
        INTERVAL_W'(MAX_INTERVAL_S * 1000 / TICK_TIME_MS);
    localparam int unsigned TIMER_W            = 9;

    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_MEASURE,
        ST_RESET_PULSE,
        ST_MANUAL_HOLD,
        ST_RUN
    } mode_t;

endpackage : wake_timer_pkg

// ==== core/wake_timer_watchdog.sv ====
// wake timer with watchdog, manual reset and start-up interval measurement
`timescale 1ns/10ps
`default_nettype none
module wake_timer_watchdog
    import wake_timer_pkg::*;
#(
    // reference cycles per oscillator tick; the default is the true 10 ms tick
    parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_ack,
    input  wire logic                  i_manual_reset,
    input  wire logic                  i_meas_done,
    input  wire logic [INTERVAL_W-1:0] i_meas_interval,
    output logic                       o_wake,
    output logic                       o_host_reset_n,
    output logic                       o_meas_enable
);
    tick_if tk ();

    // tick source shared by every timer below
    osc_tick #(
        .DIV       (TICK_DIV)
    ) u_osc_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .tk        (tk.source)
    );

    // two-stage synchronisers for the asynchronous pins
    logic [1:0] ack_sync;
    logic [1:0] mr_sync;
    logic [1:0] done_sync;
    logic       ack_prev;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ack_sync  <= 2'h0;
            mr_sync   <= 2'h0;
            done_sync <= 2'h0;
            ack_prev  <= 1'b0;
        end else begin
            ack_sync  <= {ack_sync[0], i_ack};
            mr_sync   <= {mr_sync[0], i_manual_reset};
            done_sync <= {done_sync[0], i_meas_done};
            ack_prev  <= ack_sync[1];
        end
    end

    // the measured word comes from the analog chain's domain; it is settled
    // before the done strobe, so two plain register stages are enough here
    logic [INTERVAL_W-1:0] ivl_meta;
    logic [INTERVAL_W-1:0] ivl_sync;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ivl_meta <= '0;
            ivl_sync <= '0;
        end else begin
            ivl_meta <= i_meas_interval;
            ivl_sync <= ivl_meta;
        end
    end

    wire ack_s  = ack_sync[1];
    wire mr_s   = mr_sync[1];
    wire done_s = done_sync[1];

    wire ack_rise = ack_s & ~ack_prev;

    // manual reset debounce: high on consecutive ticks, any low restarts
    logic [1:0] mr_cnt;
    logic       mr_valid;
    wire mr_qualify = tk.tick & mr_s &
                      (mr_cnt == 2'(DEBOUNCE_TICKS - 1));

    // glitches shorter than one 10 ms tick rejected
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !mr_s) begin
            mr_cnt <= 2'h0;
        end else if (tk.tick && mr_cnt != 2'(DEBOUNCE_TICKS)) begin
            mr_cnt <= mr_cnt + 2'h1;
        end
    end

    assign mr_valid = mr_qualify;

    // state and counters
    mode_t                 mode;
    mode_t                 next_mode;
    logic [INTERVAL_W-1:0] interval;
    logic [INTERVAL_W-1:0] ivl_cnt;
    logic [TIMER_W-1:0]    timer;
    logic                  first_ivl;
    logic                  acked;
    logic                  missed;
    logic                  have_interval;

    // clamp measured interval into the supported range
    function automatic logic [INTERVAL_W-1:0] clamp_ivl(input logic [INTERVAL_W-1:0] v);
        if (v < MIN_INTERVAL_TICKS) begin
            clamp_ivl = MIN_INTERVAL_TICKS;
        end else if (v > MAX_INTERVAL_TICKS) begin
            clamp_ivl = MAX_INTERVAL_TICKS;
        end else begin
            clamp_ivl = v;
        end
    endfunction : clamp_ivl

    wire ivl_end    = tk.tick & (ivl_cnt == interval - 1'b1);
    // ack window closes 20 ms before the next wake
    wire ack_window = (ivl_cnt + INTERVAL_W'(ACK_GUARD_TICKS)) < interval;
    wire timer_end  = tk.tick & (timer == TIMER_W'(RESET_PULSE_TICKS - 1));
    // conversion takes a fixed number of ticks at most
    wire meas_end   = done_s | (tk.tick & (timer == TIMER_W'(CONVERSION_TICKS - 1)));

    // next-state selection
    always_comb begin
        next_mode = mode;
        case (mode)
            ST_POWER_UP:    next_mode = mr_s ? ST_POWER_UP : ST_MEASURE;
            // pin at supply holds off interval setting
            ST_MEASURE:     next_mode = mr_s ? ST_POWER_UP :
                                        (meas_end ? ST_RESET_PULSE : ST_MEASURE);
            ST_RESET_PULSE: next_mode = mr_valid ? ST_MANUAL_HOLD :
                                        (timer_end ? ST_RUN : ST_RESET_PULSE);
            // wait for release, then a full reset pulse
            ST_MANUAL_HOLD: next_mode = mr_s ? ST_MANUAL_HOLD : ST_RESET_PULSE;
            ST_RUN:         next_mode = mr_valid ? ST_MANUAL_HOLD :
                                        ((ivl_end && !acked && !first_ivl) ?
                                         ST_RESET_PULSE : ST_RUN);
            default:        next_mode = ST_POWER_UP;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode <= ST_POWER_UP;
        end else begin
            mode <= next_mode;
        end
    end

    // interval captured once per measurement, never again
    // measurement result is the terminal count
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            interval      <= MIN_INTERVAL_TICKS;
            have_interval <= 1'b0;
        end else if (mode == ST_MEASURE && next_mode == ST_RESET_PULSE && !have_interval) begin
            interval      <= clamp_ivl(ivl_sync);
            have_interval <= 1'b1;
        end
    end

    // shared tick timer for measurement and reset pulse
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || next_mode != mode) begin
            timer <= '0;
        end else if (tk.tick) begin
            timer <= timer + 1'b1;
        end
    end

    // interval timer free-runs in run mode, ack never touches it
    // counters restart on every reset entry
    // interval starts when the reset pulse ends
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || mode != ST_RUN) begin
            ivl_cnt <= '0;
        end else if (ivl_end) begin
            ivl_cnt <= '0;
        end else if (tk.tick) begin
            ivl_cnt <= ivl_cnt + 1'b1;
        end
    end

    // first interval after reset needs no ack and issues no wake
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || mode != ST_RUN) begin
            first_ivl <= 1'b1;
        end else if (ivl_end) begin
            first_ivl <= 1'b0;
        end
    end

    // latch first ack, later edges ignored until next interval
    // late acks fall outside the window and do not count
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || mode != ST_RUN || ivl_end) begin
            acked <= 1'b0;
        end else if (ack_rise && ack_window) begin
            acked <= 1'b1;
        end
    end

    assign missed = ivl_end & ~acked & ~first_ivl;

    // wake pulse generator
    logic [TIMER_W-1:0] wake_cnt;
    logic               next_wake;
    // wake at interval start, skipped for first and after a miss
    wire wake_start = (mode == ST_RUN) & ivl_end & ~missed & ~mr_valid;
    wire wake_stop  = tk.tick & (wake_cnt == TIMER_W'(WAKE_PULSE_TICKS - 1));

    always_comb begin
        next_wake = o_wake;
        if (wake_start) begin
            next_wake = 1'b1;
        end else if (next_mode != ST_RUN || wake_stop) begin
            // manual reset forces wake low
            // looking at the next mode drops wake in the same edge as reset
            next_wake = 1'b0;
        end else if (ack_rise && !acked && ack_window) begin
            next_wake = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_wake   <= 1'b0;
            wake_cnt <= '0;
        end else begin
            o_wake   <= next_wake;
            wake_cnt <= (wake_start || !o_wake) ? '0 :
                        (tk.tick ? wake_cnt + 1'b1 : wake_cnt);
        end
    end

    // reset low through power-up and measurement
    // low through hold and pulse width; stays high while the pin debounces in run
    // analog path enabled only while measuring
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_host_reset_n <= 1'b0;
            o_meas_enable  <= 1'b0;
        end else begin
            o_host_reset_n <= (next_mode == ST_RUN);
            o_meas_enable  <= (next_mode == ST_MEASURE) && !have_interval;
        end
    end

endmodule : wake_timer_watchdog
`default_nettype wire

// ==== testbench/host_model.sv ====
// sleeping host model: answers wake pulses with an acknowledge edge
`timescale 1ns/10ps
`default_nettype none
module host_model
    import wake_timer_pkg::*;
#(
    parameter int T = TICK_CYCLES
)
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_wake,
    input  wire logic [1:0] i_mode,
    output var  logic       o_ack
);
    logic wake_q = 1'b0;
    int   delay  = -20;
    initial o_ack = 1'b0;
    // edge comes after the wake rise and well before the guard window
    // mode 0 answers at once, 1 four ticks late, 2 never; pulse lasts 20 cycles
    always @(negedge i_ref_clk) begin
        wake_q <= i_wake;
        if (i_wake && !wake_q && i_mode != 2'h2) begin
            delay <= (i_mode == 2'h0) ? 3 : 4 * T;
        end else if (delay > -20) begin
            delay <= delay - 1;
        end
        o_ack <= (delay <= 0 && delay > -20);
    end
endmodule : host_model
`default_nettype wire

// ==== testbench/wake_timer_checker.sv ====
// port-level assertion checker for the wake timer watchdog
`timescale 1ns/10ps
`default_nettype none
module wake_timer_checker
    import wake_timer_pkg::*;
#(
    parameter int T = TICK_CYCLES
)
(
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst,
    input wire logic                  i_ack,
    input wire logic                  i_manual_reset,
    input wire logic                  i_meas_done,
    input wire logic [INTERVAL_W-1:0] i_meas_interval,
    input wire logic                  o_wake,
    input wire logic                  o_host_reset_n,
    input wire logic                  o_meas_enable
);
    int   gap;
    int   low;
    int   hi;
    int   man;
    logic measured;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // spans between events; man keeps aborted measurements out of the once flag
    always_ff @(posedge i_ref_clk) begin
        gap      <= (i_rst || $rose(o_wake) || $rose(o_host_reset_n)) ? 0 : gap + 1;
        low      <= o_host_reset_n ? 0 : low + 1;
        hi       <= o_wake ? hi + 1 : 0;
        man      <= i_manual_reset ? man + 1 : 0;
        measured <= !i_rst && (measured || ($fell(o_meas_enable) && man == 0));
    end
    sequence s_ack_in_wake;
        $rose(i_ack) && o_wake;
    endsequence
    sequence s_period_end;
        $rose(o_wake) || ($fell(o_host_reset_n) && man == 0);
    endsequence
    chk_reset_defaults: assert property ($fell(i_rst) |-> !o_wake && !o_host_reset_n)
        else $error("outputs not at defaults after reset");
    chk_meas_holds_low: assert property (o_meas_enable |-> !o_host_reset_n)
        else $error("host reset released during measurement");
    chk_wake_in_run: assert property (o_wake |-> o_host_reset_n && hi <= WAKE_PULSE_TICKS * T + 4)
        else $error("wake outside run or too long");
    chk_ack_truncates: assert property (s_ack_in_wake |-> ##[1:6] !o_wake)
        else $error("acknowledge did not end wake");
    chk_interval_length: assert property (s_period_end |->
        gap >= int'(i_meas_interval) * T - 4 && gap <= int'(i_meas_interval) * T + 4)
        else $error("interval length wrong");
    chk_reset_width: assert property ($rose(o_host_reset_n) |-> low >= RESET_PULSE_TICKS * T - 4)
        else $error("host reset pulse too short");
    chk_manual_forces: assert property (man > (DEBOUNCE_TICKS + 1) * T + 4 |->
        !o_host_reset_n && !o_wake && !o_meas_enable)
        else $error("held manual reset not honoured");
    chk_measure_once: assert property (measured |-> !o_meas_enable)
        else $error("second measurement started");
endmodule : wake_timer_checker
bind wake_timer_watchdog wake_timer_checker #(.T(TICK_DIV)) chk (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ack(i_ack), .i_manual_reset(i_manual_reset), .i_meas_done(i_meas_done),
    .i_meas_interval(i_meas_interval), .o_wake(o_wake), .o_host_reset_n(o_host_reset_n),
    .o_meas_enable(o_meas_enable));
`default_nettype wire

// ==== testbench/wake_timer_watchdog_tb.sv ====
// self-checking bench for the wake timer watchdog
`timescale 1ns/10ps
`default_nettype none
module wake_timer_watchdog_tb
    import wake_timer_pkg::*;
;
    logic                  clk = 1'b0, rst = 1'b1, man = 1'b0, done = 1'b0;
    logic [INTERVAL_W-1:0] ivl = 20'h0000a;
    logic [1:0]            mode = 2'h0;
    logic                  ack, wake, host_reset_n, meas;
    logic [2:0]            outs;
    logic [31:0]           seed = 32'h00005f33;
    int                    fails = 0, checks_done = 0, n, iv;
    // shortened tick keeps the whole run to a few thousand cycles
    localparam int         TB_TICK = 20;
    assign outs = {meas, host_reset_n, wake};
    always #50 clk = ~clk;
    wake_timer_watchdog #(.TICK_DIV(TB_TICK)) DUT (.i_ref_clk(clk), .i_rst(rst), .i_ack(ack),
        .i_manual_reset(man),
        .i_meas_done(done), .i_meas_interval(ivl), .o_wake(wake), .o_host_reset_n(host_reset_n),
        .o_meas_enable(meas));
    host_model #(.T(TB_TICK)) host (.i_ref_clk(clk), .i_wake(wake), .i_mode(mode), .o_ack(ack));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xorshift
    function automatic int cyc(input int ticks);
        return ticks * TB_TICK;
    endfunction : cyc
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // a span check: seen is the in-range flag
    task automatic near(input int got, input int lo, input int hi);
        check(32'(got >= lo && got <= hi), 32'h1);
    endtask : near
    // bounded wait on one output; running out ends the run as a failure
    task automatic wait_for(input int sel, input logic val, input int lim);
        n = 0;
        while (outs[sel] !== val) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                fails++;
                print_verdict();
            end
        end
    endtask : wait_for
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        seed = xorshift(seed);
        ivl  = 20'h0000a + 20'(seed % 3);
        iv   = int'(ivl);
        repeat (16) @(negedge clk);
        // defaults, one measurement, then the reset pulse
        check({29'h0, outs}, 32'h0);
        rst = 1'b0;
        wait_for(2, 1'b1, 8);
        repeat (40) @(negedge clk);
        done = 1'b1;
        wait_for(2, 1'b0, 16);
        check(32'(host_reset_n), 32'h0);
        wait_for(1, 1'b1, cyc(34));
        near(n, cyc(31), cyc(33));
        $display("test done: start-up");
        // first interval silent, then wake cut by a prompt edge
        wait_for(0, 1'b1, cyc(iv + 1));
        near(n, cyc(iv) - 8, cyc(iv) + 8);
        wait_for(0, 1'b0, 20);
        near(n, 1, 12);
        // the edge leaves the interval alone; late edge gives full wake
        mode = 2'h1;
        wait_for(0, 1'b1, cyc(iv + 1));
        near(n, cyc(iv) - 20, cyc(iv));
        wait_for(0, 1'b0, cyc(3));
        near(n, cyc(2) - 4, cyc(2) + 4);
        repeat (cyc(3)) @(negedge clk);
        mode = 2'h2;
        wait_for(0, 1'b1, cyc(iv));
        // silent host gets a reset, not a wake
        wait_for(1, 1'b0, cyc(iv + 1));
        near(n, cyc(iv) - 4, cyc(iv) + 4);
        check(32'(wake), 32'h0);
        wait_for(1, 1'b1, cyc(33));
        near(n, cyc(32) - 4, cyc(32) + 4);
        check(32'(wake), 32'h0);
        mode = 2'h0;
        $display("test done: watchdog");
        // a random glitch shorter than a tick is filtered out
        seed = xorshift(seed);
        man  = 1'b1;
        repeat (1 + int'(seed % 32'(TB_TICK - 2))) @(negedge clk);
        man = 1'b0;
        repeat (cyc(2)) @(negedge clk);
        check(32'(host_reset_n), 32'h1);
        // held pin forces defaults, counting resumes on release
        man = 1'b1;
        wait_for(1, 1'b0, cyc(3));
        near(n, cyc(1) - 4, cyc(3));
        repeat (cyc(4)) @(negedge clk);
        check({30'h0, host_reset_n, wake}, 32'h0);
        man = 1'b0;
        wait_for(1, 1'b1, cyc(36));
        near(n, cyc(31), cyc(35));
        wait_for(0, 1'b1, cyc(iv + 1));
        near(n, cyc(iv) - 4, cyc(iv) + 4);
        $display("test done: manual reset");
        print_verdict();
    end
endmodule : wake_timer_watchdog_tb
`default_nettype wire
